// file: design/ibar_readback.sv
// Wishbone readback bank for infoframe bar boundaries, change flags and audio fields
//
// Summary of operation
// - The lower bar start line reads as a 16-bit value, low byte at 0x89, high at 0x8A.
// - A lower bar start beyond the active line count is flagged as no lower bar.
// - The left bar end pixel reads low at 0x8B, high at 0x8C; zero means no left bar.
// - The right bar start pixel reads as 16 bits, low byte at 0x8D, high at 0x8E.
// - A right bar start beyond the maximum pixel count is flagged as no right bar.
// - Index 0x8F returns a 7-bit copy of the packet change flags.
// - Reading any flag copy clears every flag not set again in that cycle, and all-zero means nothing changed.
// - Each flag sets on a change of its packet: AVI, audio, SPD, MPEG, ACP, ISRC1, ISRC2.
// - Index 0x91 bits 7:4 hold the audio coding type code.
// - Index 0x91 bits 2:0 hold the channel count code, value plus one channels.
// - Index 0x92 bits 4:2 hold the sampling frequency code.
`timescale 1ns/1ps
`default_nettype none
module ibar_readback
    import ibar_pkg::*;
#(
    parameter int ADR_W = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Receiver packet decoder
    input wire logic avi_valid_i,
    input wire ibar_avi_t avi_i,
    input wire logic aud_valid_i,
    input wire ibar_aud_t aud_i,
    input wire logic [IBAR_FLAG_N-1:0] packet_change_i,
    input wire logic flag_clr_i,
    // Video timing limits
    input wire logic [15:0] active_lines_i,
    input wire logic [15:0] max_pixels_i,
    // Status
    output logic [IBAR_FLAG_N-1:0] packet_change_flags_o,
    output logic flag_read_o,
    output logic no_lower_bar_o,
    output logic no_left_bar_o,
    output logic no_right_bar_o
);
    ibar_avi_t avi_q;
    ibar_aud_t aud_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic no_lower_q;
    logic no_left_q;
    logic no_right_q;
    logic [IBAR_FLAG_N-1:0] flags;

    if (ADR_W < IBAR_MIN_ADR_W) begin : g_chk
        $error("ibar_readback address too narrow for its register map");
    end

    // Bus decode
    wire req = wb_cyc_i & wb_stb_i;
    wire take = req & ~ack_q;
    wire rd_take = take & ~wb_we_i;
    wire [7:0] idx = wb_adr_i[9:2];
    wire adr_clean = (wb_adr_i[1:0] == 2'h0) && ((wb_adr_i >> 10) == '0);
    wire hit_llo = adr_clean && (idx == IBAR_IDX_LOWER_LO);
    wire hit_lhi = adr_clean && (idx == IBAR_IDX_LOWER_HI);
    wire hit_plo = adr_clean && (idx == IBAR_IDX_LEFT_LO);
    wire hit_phi = adr_clean && (idx == IBAR_IDX_LEFT_HI);
    wire hit_rlo = adr_clean && (idx == IBAR_IDX_RIGHT_LO);
    wire hit_rhi = adr_clean && (idx == IBAR_IDX_RIGHT_HI);
    wire hit_flg = adr_clean && (idx == IBAR_IDX_FLAGS);
    wire hit_ver = adr_clean && (idx == IBAR_IDX_AUD_VER);
    wire hit_fmt = adr_clean && (idx == IBAR_IDX_AUD_FMT);
    wire hit_sr = adr_clean && (idx == IBAR_IDX_AUD_SR);

    // Field packing of the audio bytes
    wire [7:0] fmt_byte = {aud_q.audio_format_code, 1'b0, aud_q.audio_channel_number};
    wire [7:0] sr_byte = {3'h0, aud_q.sample_rate_code, 2'h0};

    // Read selection; unmapped indices read zero
    wire [7:0] rd_byte = ({8{hit_llo}} & avi_q.lower_bar_start[7:0])
                       | ({8{hit_lhi}} & avi_q.lower_bar_start[15:8])
                       | ({8{hit_plo}} & avi_q.left_bar_end[7:0])
                       | ({8{hit_phi}} & avi_q.left_bar_end[15:8])
                       | ({8{hit_rlo}} & avi_q.right_bar_start[7:0])
                       | ({8{hit_rhi}} & avi_q.right_bar_start[15:8])
                       | ({8{hit_flg}} & {1'b0, flags})
                       | ({8{hit_ver}} & aud_q.version)
                       | ({8{hit_fmt}} & fmt_byte)
                       | ({8{hit_sr}} & sr_byte);

    // Change detection from new packet content
    wire avi_chg = avi_valid_i && (avi_i != avi_q);
    wire aud_chg = aud_valid_i && (aud_i != aud_q);
    wire [IBAR_FLAG_N-1:0] flag_set = packet_change_i
                                    | ({{(IBAR_FLAG_N-1){1'b0}}, avi_chg} << IBAR_FLAG_AVI)
                                    | ({{(IBAR_FLAG_N-1){1'b0}}, aud_chg} << IBAR_FLAG_AUD);
    wire own_clr = rd_take & hit_flg;
    wire flag_clr = own_clr | flag_clr_i;

    // Sticky change flags shared by every copy
    ibar_flags #(
        .N(IBAR_FLAG_N)
    ) u_flags (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .set_i(flag_set),
        .clr_i(flag_clr),
        .flags_o(flags)
    );

    // Wishbone answer: one cycle after the request, writes acknowledged and dropped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= take;
            if (rd_take) begin
                dat_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // Receiver refresh; the bus never writes these
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            avi_q <= IBAR_RST_AVI;
            aud_q <= IBAR_RST_AUD;
        end else begin
            if (avi_valid_i) begin
                avi_q <= avi_i;
            end
            if (aud_valid_i) begin
                aud_q <= aud_i;
            end
        end
    end

    // Bar presence status from the held boundaries
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            no_lower_q <= 1'b0;
            no_left_q <= 1'b1;
            no_right_q <= 1'b0;
        end else begin
            no_lower_q <= avi_q.lower_bar_start > active_lines_i;
            no_left_q <= avi_q.left_bar_end == IBAR_RST_BAR;
            no_right_q <= avi_q.right_bar_start > max_pixels_i;
        end
    end

    // Output drive
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign packet_change_flags_o = flags;
    assign flag_read_o = own_clr;
    assign no_lower_bar_o = no_lower_q;
    assign no_left_bar_o = no_left_q;
    assign no_right_bar_o = no_right_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ack_timing_a: assert property (take |=> ack_q ##1 !ack_q)
        else $error("ack not a single cycle after request");
    lower_low_a: assert property (rd_take && hit_llo |=>
                                  wb_dat_o == {24'h0, $past(avi_q.lower_bar_start[7:0])})
        else $error("lower bar low byte wrong");
    lower_high_a: assert property (rd_take && hit_lhi |=>
                                   wb_dat_o == {24'h0, $past(avi_q.lower_bar_start[15:8])})
        else $error("lower bar high byte wrong");
    no_lower_a: assert property (##1 no_lower_bar_o ==
                                 ($past(avi_q.lower_bar_start) > $past(active_lines_i)))
        else $error("lower bar absence wrong");
    left_bar_a: assert property (rd_take && hit_phi |=>
                                 wb_dat_o[7:0] == $past(avi_q.left_bar_end[15:8])
                                 && no_left_bar_o == ($past(avi_q.left_bar_end) == 16'h0))
        else $error("left bar readback wrong");
    right_low_a: assert property (rd_take && hit_rlo |=>
                                  wb_dat_o == {24'h0, $past(avi_q.right_bar_start[7:0])})
        else $error("right bar low byte wrong");
    no_right_a: assert property (##1 no_right_bar_o ==
                                 ($past(avi_q.right_bar_start) > $past(max_pixels_i)))
        else $error("right bar absence wrong");
    flag_copy_a: assert property (rd_take && hit_flg |=>
                                  wb_dat_o == {25'h0, $past(flags)})
        else $error("flag copy wrong");
    flag_clear_a: assert property (own_clr && flag_set == '0 |=> flags == '0 ##1 wb_ack_o == 1'b0)
        else $error("flag read did not clear");
    avi_flag_a: assert property (avi_chg |=> flags[IBAR_FLAG_AVI])
        else $error("AVI change not flagged");
    fmt_byte_a: assert property (rd_take && hit_fmt |=>
                                 wb_dat_o[7:4] == $past(aud_q.audio_format_code)
                                 && wb_dat_o[2:0] == $past(aud_q.audio_channel_number))
        else $error("audio format byte wrong");
    sr_byte_a: assert property (rd_take && hit_sr |=>
                                wb_dat_o == {27'h0, $past(aud_q.sample_rate_code), 2'h0})
        else $error("sample rate byte wrong");
    write_void_a: assert property (take && wb_we_i && !avi_valid_i && !aud_valid_i |=>
                                   $stable(avi_q) && $stable(aud_q))
        else $error("write changed a read-only register");

    flag_read_c: cover property (rd_take && hit_flg && flags != '0);
    bus_write_c: cover property (take && wb_we_i);
    avi_update_c: cover property (avi_chg ##[1:8] rd_take && hit_llo);
    set_clear_c: cover property (own_clr && flag_set != '0);
endmodule
`default_nettype wire

// file: design/ibar_pkg.sv
// Constants and carrier types for the infoframe bar and audio readback bank
package ibar_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IBAR_IDX_LOWER_LO = 8'h89;
    localparam logic [7:0] IBAR_IDX_LOWER_HI = 8'h8a;
    localparam logic [7:0] IBAR_IDX_LEFT_LO = 8'h8b;
    localparam logic [7:0] IBAR_IDX_LEFT_HI = 8'h8c;
    localparam logic [7:0] IBAR_IDX_RIGHT_LO = 8'h8d;
    localparam logic [7:0] IBAR_IDX_RIGHT_HI = 8'h8e;
    localparam logic [7:0] IBAR_IDX_FLAGS = 8'h8f;
    localparam logic [7:0] IBAR_IDX_AUD_VER = 8'h90;
    localparam logic [7:0] IBAR_IDX_AUD_FMT = 8'h91;
    localparam logic [7:0] IBAR_IDX_AUD_SR = 8'h92;

    // Field widths and positions
    localparam int IBAR_FLAG_N = 7;
    localparam int IBAR_FLAG_AVI = 0;
    localparam int IBAR_FLAG_AUD = 1;
    localparam int IBAR_FMT_CODE_LSB = 4;
    localparam int IBAR_FMT_CHAN_LSB = 0;
    localparam int IBAR_SR_CODE_LSB = 2;
    localparam int IBAR_MIN_ADR_W = 10;

    // Reset values
    localparam logic [15:0] IBAR_RST_BAR = 16'h0000;
    localparam logic [7:0] IBAR_RST_BYTE = 8'h00;
    localparam logic [3:0] IBAR_RST_CODE = 4'h0;
    localparam logic [2:0] IBAR_RST_CHAN = 3'h0;
    localparam logic [2:0] IBAR_RST_SR = 3'h0;
    localparam logic [6:0] IBAR_RST_FLAGS = 7'h00;

    // Decoded bar and pillar boundaries of the video infoframe
    typedef struct packed {
        logic [15:0] lower_bar_start;
        logic [15:0] left_bar_end;
        logic [15:0] right_bar_start;
    } ibar_avi_t;

    // Decoded fields of the audio infoframe
    typedef struct packed {
        logic [7:0] version;
        logic [3:0] audio_format_code;
        logic [2:0] audio_channel_number;
        logic [2:0] sample_rate_code;
    } ibar_aud_t;

    localparam ibar_avi_t IBAR_RST_AVI = '{IBAR_RST_BAR, IBAR_RST_BAR, IBAR_RST_BAR};
    localparam ibar_aud_t IBAR_RST_AUD = '{IBAR_RST_BYTE, IBAR_RST_CODE, IBAR_RST_CHAN,
                                           IBAR_RST_SR};
endpackage

// file: design/ibar_flags.sv
// Sticky packet change flags with a shared clear
`timescale 1ns/1ps
`default_nettype none
module ibar_flags
    import ibar_pkg::*;
#(
    parameter int N = IBAR_FLAG_N
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Events and clear
    input wire logic [N-1:0] set_i,
    input wire logic clr_i,
    // Flag state
    output logic [N-1:0] flags_o
);
    logic [N-1:0] flag_q;

    if (N < 1) begin : g_chk
        $error("ibar_flags needs at least one flag");
    end

    // One sticky bit per packet type; a set in the clear cycle wins
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                flag_q[i] <= 1'b0;
            end else begin
                flag_q[i] <= set_i[i] | (flag_q[i] & ~clr_i);
            end
        end
    end

    assign flags_o = flag_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    set_wins_a: assert property (clr_i && set_i[0] |=> flag_q[0])
        else $error("flag set lost against clear");
    clear_all_a: assert property (clr_i && set_i == '0 |=> flag_q == '0)
        else $error("flags not cleared");
endmodule
`default_nettype wire

// file: sim/ibar_src_model.sv
// Behavioural infoframe source that loads decoded packet fields into the bank
`timescale 1ns/1ps
`default_nettype none
module ibar_src_model
    import ibar_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Decoded packet outputs
    output logic avi_valid_o,
    output ibar_avi_t avi_o,
    output logic aud_valid_o,
    output ibar_aud_t aud_o,
    output logic [IBAR_FLAG_N-1:0] pkt_o
);
    // Idle: no load, data lines parked on a junk pattern
    initial begin
        avi_valid_o = 1'b0;
        avi_o = '1;
        aud_valid_o = 1'b0;
        aud_o = '1;
        pkt_o = '0;
    end
    // One load cycle; afterwards the lines no longer hold the value
    task automatic send_avi(input ibar_avi_t v);
        @(posedge clk_i);
        avi_valid_o <= 1'b1;
        avi_o <= v;
        @(posedge clk_i);
        avi_valid_o <= 1'b0;
        avi_o <= ~v;
    endtask
    task automatic send_aud(input ibar_aud_t v);
        @(posedge clk_i);
        aud_valid_o <= 1'b1;
        aud_o <= v;
        @(posedge clk_i);
        aud_valid_o <= 1'b0;
        aud_o <= ~v;
    endtask
    // One-cycle change event for a packet kind
    task automatic pulse_pkt(input int b);
        @(posedge clk_i);
        pkt_o <= 7'(1 << b);
        @(posedge clk_i);
        pkt_o <= '0;
    endtask
endmodule
`default_nettype wire

// file: sim/test_infoframe_bar_audio_readback.sv
// Self-checking bench for the infoframe bar and audio readback bank
`timescale 1ns/1ps
`default_nettype none
module test_infoframe_bar_audio_readback;
    import ibar_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [9:0] adr = '0;
    logic [31:0] dat = '0;
    logic fclr = 1'b0;
    logic [15:0] act_lines = 16'h0437;
    logic [15:0] max_pix = 16'h0780;
    wire logic [31:0] rdat;
    wire logic ack, avi_v, aud_v, flag_rd, nlow, nleft, nright;
    wire ibar_avi_t avi;
    wire ibar_aud_t aud;
    wire logic [6:0] pkt, flags;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc_cnt = 0;
    int rd_cnt = 0;
    int i;
    logic [31:0] d;
    ibar_aud_t av;
    // Clock and hang guard
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 5000) begin
            error_cnt++;
            final_report();
        end
    end
    // Count the cycles in which the bank reports a taken flag read to other copies
    always @(posedge clk_i) begin
        if (flag_rd === 1'b1) begin
            rd_cnt++;
        end
    end
    ibar_src_model SRC (.clk_i(clk_i), .avi_valid_o(avi_v), .avi_o(avi),
        .aud_valid_o(aud_v), .aud_o(aud), .pkt_o(pkt));
    ibar_readback DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .avi_valid_i(avi_v), .avi_i(avi), .aud_valid_i(aud_v), .aud_i(aud),
        .packet_change_i(pkt), .flag_clr_i(fclr), .active_lines_i(act_lines),
        .max_pixels_i(max_pix), .packet_change_flags_o(flags), .flag_read_o(flag_rd),
        .no_lower_bar_o(nlow), .no_left_bar_o(nleft), .no_right_bar_o(nright));
    // Classic single Wishbone cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] idx, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat <= 32'h5aa5_c33c;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] idx, input logic [31:0] e, input string n);
        logic [31:0] q;
        bus(1'b0, idx, q);
        chk(n, e, q);
    endtask
    // Load bar values, read all six bytes, the status and the change flag
    task automatic avi_case(input ibar_avi_t v, input logic [2:0] st);
        int k;
        int sh;
        SRC.send_avi(v);
        for (k = 0; k < 6; k++) begin
            sh = 32 - 16 * (k / 2) + 8 * (k % 2);
            rc(IBAR_IDX_LOWER_LO + 8'(k), 32'(8'(v >> sh)), "bar_byte");
        end
        chk("bar_status", {29'h0, st}, {29'h0, nlow, nleft, nright});
        chk("flags_out", 32'h1, {25'h0, flags});
        rc(IBAR_IDX_FLAGS, 32'h1, "flags_avi");
        rc(IBAR_IDX_FLAGS, 32'h0, "flags_cleared");
        chk("flags_out_clr", 32'h0, {25'h0, flags});
    endtask
    task automatic final_report();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(IBAR_IDX_FLAGS, 32'h0, "flags_reset");
        chk("no_left_reset", 32'h1, {31'h0, nleft});
        avi_case('{16'h0438, 16'h00f0, 16'h0781}, 3'b101);
        avi_case('{16'h0437, 16'h0000, 16'h0780}, 3'b010);
        // Coding types 0 to 8, every channel count and rate codes 0 to 6
        for (i = 0; i < 9; i++) begin
            av = '{8'h10 + 8'(i), 4'(i), 3'(i), 3'(i % 7)};
            SRC.send_aud(av);
            rc(IBAR_IDX_AUD_VER, {24'h0, av.version}, "aud_version");
            rc(IBAR_IDX_AUD_FMT, {24'h0, av.audio_format_code, 1'b0,
                av.audio_channel_number}, "aud_format");
            rc(IBAR_IDX_AUD_SR, {27'h0, av.sample_rate_code, 2'b00}, "aud_rate");
            rc(IBAR_IDX_FLAGS, 32'h2, "flags_aud");
        end
        // Each change event sets its own bit only
        for (i = 0; i < 7; i++) begin
            SRC.pulse_pkt(i);
            rc(IBAR_IDX_FLAGS, 32'(1 << i), "flags_event");
        end
        // A read of another copy clears this one too
        SRC.pulse_pkt(3);
        @(posedge clk_i);
        fclr <= 1'b1;
        @(posedge clk_i);
        fclr <= 1'b0;
        rc(IBAR_IDX_FLAGS, 32'h0, "flags_other_clear");
        // Writes are ignored; unmapped place reads zero
        bus(1'b1, IBAR_IDX_LOWER_LO, d);
        rc(IBAR_IDX_LOWER_LO, 32'h37, "write_ignored");
        rc(8'h93, 32'h0, "unmapped");
        chk("flag_read_cnt", 32'h16, 32'(rd_cnt));
        final_report();
    end
endmodule
`default_nettype wire
